// ==== hw/itap_host.sv ====
`timescale 1ns/10ps
module itap_host
	import itap_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic rst_n,
	// chain
	itap_if.host link,
	// command
	input wire logic cmdValid,
	output logic cmdReady,
	input wire itap_cmd_t cmdOp,
	input wire logic [DR_W-1:0] cmdData,
	input wire logic [SH_CNT_W-1:0] cmdLen,
	// result
	output logic [DR_W-1:0] rspData,
	output logic rspValid,
	output logic idMatch
);
	typedef enum logic [2:0] {H_IDLE, H_RESET, H_PRE, H_SHIFT, H_POST} itap_hst_t;
	typedef struct packed {
		itap_hst_t st;
		logic [2:0] div;
		logic tck;
		logic tms;
		logic tdi;
		logic [1:0] tdoS;
		logic [2:0] step;
		logic [SH_CNT_W-1:0] left;
		logic isIr;
		logic [DR_W-1:0] sh;
		logic [DR_W-1:0] rsp;
		logic rspV;
		logic idOk;
	} itap_host_t;
	itap_host_t s_r, s_nxt;
	logic rise, fall, go;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tdoS = {s_r.tdoS[0], link.tdo};
		s_nxt.rspV = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		go = 1'b0;
		if (s_r.st != H_IDLE) begin
			s_nxt.div = s_r.div + 3'd1;
			if (s_r.div == 3'(TCK_HALF - 1)) begin
				s_nxt.div = '0;
				s_nxt.tck = ~s_r.tck;
				rise = ~s_r.tck;
				fall = s_r.tck;
			end
		end
		case (s_r.st)
			H_IDLE: begin
				if (cmdValid) begin
					s_nxt.step = '0;
					s_nxt.sh = cmdData;
					s_nxt.left = cmdLen;
					s_nxt.isIr = (cmdOp == CMD_IR);
					s_nxt.st = (cmdOp == CMD_RESET) ? H_RESET : H_PRE;
					s_nxt.tms = (cmdOp == CMD_RESET);
				end
			end
			H_RESET: begin
				if (rise) begin
					s_nxt.step = s_r.step + 3'd1;
				end
				// leave on a falling edge so tck idles low
				if (fall && s_r.step == 3'(RESET_PULSES)) begin
					s_nxt.st = H_IDLE;
				end
			end
			H_PRE: begin
				// tms and tdi registered, changed at falling tck
				if (fall) begin
					s_nxt.step = s_r.step + 3'd1;
					case (s_r.step)
						3'd0: s_nxt.tms = 1'b0;
						3'd1: s_nxt.tms = 1'b1;
						3'd2: s_nxt.tms = s_r.isIr;
						3'd3: s_nxt.tms = 1'b0;
						// ir path needs one more step, through select-ir before capture
						3'd4: begin
							s_nxt.tms = 1'b0;
							go = !s_r.isIr;
						end
						default: go = 1'b1;
					endcase
					// first bit goes out on the falling edge after the device enters shift
					if (go) begin
						s_nxt.tms = (s_r.left == 6'd1);
						s_nxt.tdi = s_r.sh[0];
						s_nxt.st = H_SHIFT;
					end
				end
			end
			H_SHIFT: begin
				// tdo taken half a period late: both syncs eat five clocks
				if (fall) begin
					// tdo kept in its true polarity
					s_nxt.rsp = {s_r.tdoS[1], s_r.rsp[DR_W-1:1]};
					s_nxt.left = s_r.left - 6'd1;
					s_nxt.sh = {1'b0, s_r.sh[DR_W-1:1]};
					s_nxt.tdi = s_r.sh[1];
					s_nxt.tms = (s_r.left == 6'd2);
					if (s_r.left == 6'd1) begin
						s_nxt.tms = 1'b1;
						s_nxt.step = '0;
						s_nxt.st = H_POST;
					end
				end
			end
			H_POST: begin
				// exit1 to update, then update to idle
				if (fall) begin
					s_nxt.step = s_r.step + 3'd1;
					s_nxt.tms = 1'b0;
					if (s_r.step == 3'd1) begin
						s_nxt.st = H_IDLE;
						s_nxt.rspV = 1'b1;
						s_nxt.idOk = (s_r.rsp == DEV_IDCODE);
					end
				end
			end
			default: s_nxt.st = H_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.tms <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.tck = s_r.tck;
	assign link.tms = s_r.tms;
	assign link.tdi = s_r.tdi;
	assign cmdReady = (s_r.st == H_IDLE);
	assign rspData = s_r.rsp;
	assign rspValid = s_r.rspV;
	assign idMatch = s_r.idOk;
endmodule

// ==== common/itap_pkg.sv ====
package itap_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
		TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
		TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
	} itap_state_t;
	localparam int IR_W = 4;
	localparam int DR_W = 32;
	localparam int PRG_W = 8;
	localparam int IO_W = 8;
	// instruction codes, arbitrary choice
	localparam logic [IR_W-1:0] INS_IDCODE = 4'h1;
	localparam logic [IR_W-1:0] INS_PROG = 4'h2;
	localparam logic [IR_W-1:0] INS_DONE = 4'h3;
	localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
	// identification code, arbitrary value
	localparam logic [DR_W-1:0] DEV_IDCODE = 32'h1234_5A5B;
	// link clock divider: half period in system clocks (4 -> 320 ns period)
	localparam int TCK_HALF = 4;
	localparam int RESET_PULSES = 6;
	localparam int SH_CNT_W = 6;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	// host command opcodes
	typedef enum logic [1:0] {
		CMD_RESET, CMD_IR, CMD_DR
	} itap_cmd_t;
endpackage

// ==== common/itap_if.sv ====
`timescale 1ns/10ps
interface itap_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdoOe;
	modport device (input tck, input tms, input tdi, output tdo, output tdoOe);
	modport host (output tck, output tms, output tdi, input tdo, input tdoOe);
endinterface

// ==== hw/itap_device.sv ====
`timescale 1ns/10ps
module itap_device
	import itap_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic rst_n,
	// chain
	itap_if.device link,
	// user logic pins
	input wire logic [IO_W-1:0] userOut,
	input wire logic [IO_W-1:0] userOe,
	output logic [IO_W-1:0] pinOut,
	output logic [IO_W-1:0] pinOe,
	// programmed data stream
	output logic [PRG_W-1:0] prgData,
	output logic prgValid,
	input wire logic prgReady,
	output logic userMode
);
	typedef struct packed {
		logic [2:0] tckS;
		logic [1:0] tmsS;
		logic [1:0] tdiS;
		itap_state_t st;
		logic [IR_W-1:0] irSh;
		logic [IR_W-1:0] ir;
		logic [DR_W-1:0] drSh;
		logic tdo;
		logic tdoOe;
		logic prog;
		logic user;
		logic [1:0] bufV;
		logic [PRG_W-1:0] buf0;
		logic [PRG_W-1:0] buf1;
	} itap_dev_t;
	itap_dev_t s_r, s_nxt;
	logic rise, fall, tmsV, tdiV, push;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tckS = {s_r.tckS[1:0], link.tck};
		s_nxt.tmsS = {s_r.tmsS[0], link.tms};
		s_nxt.tdiS = {s_r.tdiS[0], link.tdi};
		// edge detect on second and third stages only
		rise = s_r.tckS[1] & ~s_r.tckS[2];
		fall = ~s_r.tckS[1] & s_r.tckS[2];
		tmsV = s_r.tmsS[1];
		tdiV = s_r.tdiS[1];
		push = 1'b0;
		if (rise) begin
			case (s_r.st)
				TAP_RESET: s_nxt.st = tmsV ? TAP_RESET : TAP_IDLE;
				TAP_IDLE: s_nxt.st = tmsV ? TAP_SEL_DR : TAP_IDLE;
				TAP_SEL_DR: s_nxt.st = tmsV ? TAP_SEL_IR : TAP_CAP_DR;
				TAP_CAP_DR: s_nxt.st = tmsV ? TAP_EX1_DR : TAP_SH_DR;
				TAP_SH_DR: s_nxt.st = tmsV ? TAP_EX1_DR : TAP_SH_DR;
				TAP_EX1_DR: s_nxt.st = tmsV ? TAP_UPD_DR : TAP_PAU_DR;
				TAP_PAU_DR: s_nxt.st = tmsV ? TAP_EX2_DR : TAP_PAU_DR;
				TAP_EX2_DR: s_nxt.st = tmsV ? TAP_UPD_DR : TAP_SH_DR;
				TAP_UPD_DR: s_nxt.st = tmsV ? TAP_SEL_DR : TAP_IDLE;
				// tms high walks to reset within five
				TAP_SEL_IR: s_nxt.st = tmsV ? TAP_RESET : TAP_CAP_IR;
				TAP_CAP_IR: s_nxt.st = tmsV ? TAP_EX1_IR : TAP_SH_IR;
				TAP_SH_IR: s_nxt.st = tmsV ? TAP_EX1_IR : TAP_SH_IR;
				TAP_EX1_IR: s_nxt.st = tmsV ? TAP_UPD_IR : TAP_PAU_IR;
				TAP_PAU_IR: s_nxt.st = tmsV ? TAP_EX2_IR : TAP_PAU_IR;
				TAP_EX2_IR: s_nxt.st = tmsV ? TAP_UPD_IR : TAP_SH_IR;
				TAP_UPD_IR: s_nxt.st = tmsV ? TAP_SEL_DR : TAP_IDLE;
				default: s_nxt.st = TAP_RESET;
			endcase
			case (s_r.st)
				TAP_CAP_IR: s_nxt.irSh = IR_CAPTURE;
				TAP_SH_IR: s_nxt.irSh = {tdiV, s_r.irSh[IR_W-1:1]};
				TAP_UPD_IR: s_nxt.ir = s_r.irSh;
				TAP_CAP_DR: s_nxt.drSh = (s_r.ir == INS_IDCODE) ? DEV_IDCODE : '0;
				TAP_SH_DR: begin
					if (s_r.ir == INS_BYPASS) begin
						s_nxt.drSh = {{(DR_W-1){1'b0}}, tdiV};
					end else begin
						s_nxt.drSh = {tdiV, s_r.drSh[DR_W-1:1]};
					end
				end
				TAP_UPD_DR: begin
					if (s_r.ir == INS_PROG) begin
						s_nxt.prog = 1'b1;
						s_nxt.user = 1'b0;
						push = 1'b1;
					end else if (s_r.ir == INS_DONE && s_r.prog) begin
						s_nxt.prog = 1'b0;
						s_nxt.user = 1'b1;
					end
				end
				TAP_RESET: s_nxt.ir = INS_IDCODE;
				default: ;
			endcase
		end
		// tdo moves on falling edge only
		if (fall) begin
			s_nxt.tdoOe = (s_r.st == TAP_SH_DR) || (s_r.st == TAP_SH_IR);
			s_nxt.tdo = (s_r.st == TAP_SH_IR) ? s_r.irSh[0] : s_r.drSh[0];
		end
		// two-entry buffer; a full buffer drops the word, as the chain cannot stall
		if (prgValid && prgReady) begin
			s_nxt.buf0 = s_r.buf1;
			s_nxt.bufV = {1'b0, s_r.bufV[1]};
		end
		if (push) begin
			if (!s_nxt.bufV[0]) begin
				s_nxt.buf0 = s_r.drSh[PRG_W-1:0];
				s_nxt.bufV[0] = 1'b1;
			end else if (!s_nxt.bufV[1]) begin
				s_nxt.buf1 = s_r.drSh[PRG_W-1:0];
				s_nxt.bufV[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.tdo = s_r.tdo;
	assign link.tdoOe = s_r.tdoOe;
	assign prgData = s_r.buf0;
	assign prgValid = s_r.bufV[0];
	assign userMode = s_r.user;
	assign pinOut = s_r.prog ? '0 : userOut;
	assign pinOe = s_r.prog ? '0 : userOe;
endmodule

// ==== bench/itap_assertions.sv ====
`timescale 1ns/10ps
module itap_assertions (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// chain
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdoOe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic tckD;
	logic seenLow;
	logic [2:0] highCnt;
	// saturates so a long reset run cannot wrap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tckD <= 1'b0;
			seenLow <= 1'b0;
			highCnt <= 3'h0;
		end else begin
			tckD <= tck;
			if (tck && !tckD) begin
				seenLow <= seenLow | !tms;
				highCnt <= !tms ? 3'h0 : (highCnt == 3'h7 ? 3'h7 : highCnt + 3'h1);
			end
		end
	end
	AST_TDO_EDGE:
		assert property ($changed(tdo) |-> !tck) else $error("tdo moved with tck high");
	AST_OE_EDGE:
		assert property ($changed(tdoOe) |-> !tck) else $error("tdoOe moved with tck high");
	AST_TMS_SETUP:
		assert property ($rose(tck) |-> $stable(tms) && $stable(tdi)) else $error("tms moved");
	AST_TCK_HIGH:
		assert property ($rose(tck) |-> tck[*4] ##1 !tck) else $error("tck high phase");
	AST_TCK_LOW:
		assert property ($fell(tck) |-> !tck[*4]) else $error("tck low phase");
	AST_SIX_RESET:
		assert property (highCnt >= 3'h6 |-> !tdoOe) else $error("no reset after six");
	AST_NO_EXIT:
		assert property (!seenLow |-> !tdoOe) else $error("left reset with tms high");
	AST_OE_SPAN:
		assert property ($rose(tdoOe) |-> tdoOe[*8]) else $error("shift too short");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	import itap_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmdValid = 1'b0;
	logic prgReady = 1'b0;
	itap_cmd_t cmdOp = CMD_RESET;
	logic [DR_W-1:0] cmdData = '0;
	logic [SH_CNT_W-1:0] cmdLen = '0;
	logic [IO_W-1:0] userOut = '0;
	logic [IO_W-1:0] userOe = '0;
	logic [DR_W-1:0] rspData, rsp, d;
	logic [IO_W-1:0] pinOut, pinOe;
	logic [PRG_W-1:0] prgData;
	logic cmdReady, rspValid, idMatch, prgValid, userMode;
	int mismatches = 0;
	int comparisons = 0;
	logic [PRG_W-1:0] prgQ[$];
	itap_if link ();
	itap_device itap_device_inst (.clk(clk), .rst_n(rst_n), .link(link), .userOut(userOut),
		.userOe(userOe), .pinOut(pinOut), .pinOe(pinOe), .prgData(prgData),
		.prgValid(prgValid), .prgReady(prgReady), .userMode(userMode));
	itap_host itap_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdOp(cmdOp), .cmdData(cmdData), .cmdLen(cmdLen),
		.rspData(rspData), .rspValid(rspValid), .idMatch(idMatch));
	itap_assertions itap_assertions_inst (.clk(clk), .rst_n(rst_n), .tck(link.tck),
		.tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdoOe(link.tdoOe));
	always #20 clk = ~clk;
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t word %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkF(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t flags %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input itap_cmd_t op, input logic [31:0] data, input logic [5:0] len);
		int n;
		n = 0;
		@(negedge clk);
		cmdOp = op;
		cmdData = data;
		cmdLen = len;
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1 && n < 4000) @(negedge clk) n++;
		@(negedge clk);
		cmdValid = 1'b0;
		while (cmdReady !== 1'b1 && n < 4000) @(negedge clk) n++;
		// let the response edge pass before anyone looks at it
		@(negedge clk);
		if (n >= 4000)
			chkF(8'h00, 8'h01);
	endtask
	// responses and program words sampled where they stand
	always @(posedge clk) begin
		if (rspValid === 1'b1)
			rsp <= rspData;
		if (prgValid === 1'b1 && prgReady === 1'b1)
			chkF(prgData, prgQ.pop_front());
	end
	initial begin
		void'($urandom(32'h8b1d_da0f));
		userOut = 8'($urandom);
		userOe = 8'($urandom);
		repeat (16) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		chkF(pinOe, userOe);
		chkF(pinOut, userOut);
		chkF(8'(userMode), 8'h00);
		cmd(CMD_RESET, 32'h0, 6'h0);
		cmd(CMD_DR, 32'h0, 6'h20);
		chkW(rsp, DEV_IDCODE);
		chkF(8'(idMatch), 8'h01);
		d = $urandom;
		cmd(CMD_IR, 32'(INS_BYPASS), 6'h4);
		cmd(CMD_DR, d, 6'h20);
		chkW(rsp, {d[30:0], 1'b0});
		chkF(8'(idMatch), 8'h00);
		cmd(CMD_IR, 32'(INS_PROG), 6'h4);
		// receiver stalled: third word finds the buffer full
		for (int i = 0; i < 3; i++) begin
			d = $urandom;
			if (i < 2)
				prgQ.push_back(d[7:0]);
			cmd(CMD_DR, d, 6'h20);
			chkF(pinOe, 8'h00);
			chkF(pinOut, 8'h00);
		end
		chkF(8'(userMode), 8'h00);
		prgReady = 1'b1;
		repeat (8) @(negedge clk);
		chkW(32'(prgQ.size()), 32'h0);
		cmd(CMD_IR, 32'(INS_DONE), 6'h4);
		// done takes effect at the update of a data scan
		cmd(CMD_DR, 32'h0, 6'h20);
		chkF(8'(userMode), 8'h01);
		chkF(pinOe, userOe);
		chkF(pinOut, userOut);
		cmd(CMD_RESET, 32'h0, 6'h0);
		cmd(CMD_DR, 32'h0, 6'h20);
		chkW(rsp, DEV_IDCODE);
		chkF(8'(link.tdoOe), 8'h00);
		end_sim;
	end
	// about twenty times the expected run
	initial begin
		#2000000;
		mismatches++;
		end_sim;
	end
endmodule
